// ==== src/memref_regs.svh ====
/*
 * Constants of the memory reference executor: register offsets,
 * status and control bit positions, operation codes and cycle timing.
 * Assumes inclusion by bare name from the module and the bench.
 */
`ifndef MEMREF_REGS_SVH
`define MEMREF_REGS_SVH

// Register port offsets (word index)
`define REG_STATUS      4'h0
`define REG_PC          4'h1
`define REG_AC          4'h2
`define REG_IO          4'h3
`define REG_MBUF        4'h4
`define REG_CONTROL     4'h5

// Status fields
`define ST_RUNNING      0
`define ST_OVERFLOW     1
`define ST_STOP_REQ     2
`define ST_SENSE_LSB    4
// Control fields
`define CTL_STOP        0
`define CTL_CONTINUE    1

// Operation codes in octal (bits 0..5 of the word, bit 5 zero)
`define OP_AND          6'o02
`define OP_IOR          6'o04
`define OP_XOR          6'o06
`define OP_LAC          6'o20
`define OP_LIO          6'o22
`define OP_DAC          6'o24
`define OP_DAP          6'o26
`define OP_DIP          6'o30
`define OP_DIO          6'o32
`define OP_ADD          6'o40
`define OP_SUB          6'o42
`define OP_IDX          6'o44
`define OP_ISP          6'o46
`define OP_SAD          6'o50
`define OP_SAS          6'o52
`define OP_MUS          6'o54
`define OP_DIS          6'o56
`define OP_JMP          6'o60
`define OP_JSP          6'o62
`define OP_IOT          6'o72

// Timing
`define CLK_PERIOD_NS   10
`define MC_TIME_NS      5000
`define MC_CLKS         (`MC_TIME_NS / `CLK_PERIOD_NS)

// Reset values
`define RST_WORD        18'h00000
`define RST_ADDR        12'h000

`endif

// ==== src/memref_pkg.sv ====
/*
 * Types of the memory reference executor: phases, console switch
 * bundle, memory request, indicator lights and the machine state.
 * Assumes memref_regs.svh on the include path.
 */
package memref_pkg;

    typedef enum logic [2:0] {
        PH_HALT, PH_FETCH, PH_DEFER, PH_EXEC, PH_IOWAIT, PH_EXAM, PH_DEP
    } phase_t;

    typedef struct packed {
        logic        start;
        logic        stop;
        logic        cont;
        logic        examine;
        logic        deposit;
        logic        read_in;
        logic        single_cycle;
        logic        test;
        logic [11:0] test_address;
        logic [17:0] test_word;
        logic [5:0]  sense;
    } console_t;

    typedef struct packed {
        logic        re;
        logic        we;
        logic [11:0] addr;
        logic [17:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        running;
        logic        overflow;
        logic [11:0] pc;
        logic [11:0] ma;
        logic [17:0] ac;
        logic [17:0] io;
        logic [17:0] memory_buffer_register;
        logic [17:0] ir;
    } lights_t;

    typedef struct packed {
        phase_t      phase;
        phase_t      resume;
        logic [15:0] cnt;
        logic [17:0] ac;
        logic [17:0] io;
        logic [17:0] mbuf;
        logic [17:0] ir;
        logic [11:0] pc;
        logic [11:0] ma;
        logic        ovf;
        logic        stop_req;
        logic        wr;
        logic        readin;
        logic        io_go;
        logic [31:0] rdata;
        console_t    sync1;
        console_t    sync2;
        console_t    prev;
    } state_t;

endpackage

// ==== src/memref_exec.sv ====
/*
 * Execution control and console of an 18-bit single-address processor.
 * Assumes a core memory that answers a read strobe with data on the next
 * clock and takes a write in the cycle its strobe is high; console
 * switches arrive asynchronously; the register port is on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

`include "memref_regs.svh"

// Functional notes
// - Instructions take whole 5 us memory cycles; memory references two, jumps one.
// - In-out transfer takes one cycle, or waits for the device when wait chosen.
// - Each indirect level adds one 5 us memory cycle.
// - Console holds 12-bit address, 18-bit word and six sense switches.
// - Start runs from the address switch location.
// - Stop halts after the current memory cycle completes.
// - Continue resumes from the held machine state.
// - Examine reads the switch address into accumulator and memory buffer.
// - Deposit writes the word switches at the switch address.
// - Read-in starts the tape reader in loading mode.
// - Single-cycle halts after every cycle; continue steps one cycle.
// - Test switch repeats the instruction at the switch address.
// - Add and subtract in ones' complement, setting overflow on excess.
// - Multiply step adds when in-out bit 17 set, then shifts pair right.
// - Divide step rotates left, in-out bit 17 takes the inverted accumulator sign, then subtracts or adds plus one.
// - Index writes operand plus one to memory and accumulator; isp skips if positive.
// - And, exclusive or, inclusive or combine operand into accumulator.
// - Load copies the word into accumulator or in-out register.
// - Store writes accumulator or in-out register to memory.
// - Deposit address part writes bits 6..17; instruction part bits 0..5.
// - Jump loads the address; jump-and-save first copies the counter.
// - Compare-skips skip on differ (50) or on identical (52).
// - Opcode in bits 0..4, indirect bit 5, address bits 6..17.
// - Words are ones' complement, bit 0 sign, bit 17 least significant.
// - Overflow is sticky, cleared only by start or reset.
module memref_exec #(
    parameter int unsigned MC_CYCLES = `MC_CLKS
) (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire memref_pkg::console_t console,
    input  wire logic [17:0]         mem_rdata,
    input  wire logic                io_done,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    output memref_pkg::mem_req_t     mem,
    output memref_pkg::lights_t      lights,
    output logic                     io_start,
    output logic                     reader_read_in
);
    import memref_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Bit k of the word is vector bit 17-k
    function automatic logic [17:0] oc_add(input logic [17:0] a, input logic [17:0] b);
        logic [18:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[17:0] + {17'h0, t[18]};
    endfunction

    function automatic logic oc_ovf(input logic [17:0] a, input logic [17:0] b,
                                    input logic [17:0] r);
        return (a[17] == b[17]) && (r[17] != a[17]);
    endfunction

    function automatic logic is_memref(input logic [5:0] op);
        return op inside {`OP_AND, `OP_IOR, `OP_XOR, `OP_LAC, `OP_LIO, `OP_DAC,
                          `OP_DAP, `OP_DIP, `OP_DIO, `OP_ADD, `OP_SUB, `OP_IDX,
                          `OP_ISP, `OP_SAD, `OP_SAS, `OP_MUS, `OP_DIS};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    state_t s;
    state_t next_s;

    localparam logic [15:0] LAST = 16'(MC_CYCLES - 1);

    logic     last;
    logic     mem_phase;
    console_t press;
    logic [5:0]  op;
    logic        ind;
    logic [17:0] y;
    logic [35:0] pair;
    logic [17:0] sum;
    logic        halting;
    phase_t      nxt;

    assign op        = {s.ir[17:13], 1'b0};
    assign ind       = s.ir[12];
    assign last      = (s.cnt == LAST);
    assign mem_phase = s.phase inside {PH_FETCH, PH_DEFER, PH_EXEC, PH_EXAM, PH_DEP};
    assign press     = s.sync2 & ~s.prev;

    always_comb begin
        next_s = s;
        next_s.readin = 1'b0;
        next_s.io_go  = 1'b0;
        nxt     = s.phase;
        halting = 1'b0;
        y       = mem_rdata;
        pair    = 36'h0;
        sum     = 18'h0;

        // Only the second stage and its copy are looked at
        next_s.sync1 = console;
        next_s.sync2 = s.sync1;
        next_s.prev  = s.sync2;

        // Memory cycle timer; held at zero outside memory cycles
        if (mem_phase) begin
            next_s.cnt = last ? 16'h0 : s.cnt + 16'h1;
        end

        unique case (s.phase)
            PH_HALT: begin
                if (press.start) begin
                    next_s.pc       = s.sync2.test_address;
                    next_s.ma       = s.sync2.test_address;
                    next_s.ovf      = 1'b0;
                    next_s.stop_req = 1'b0;
                    next_s.phase    = PH_FETCH;
                end else if (press.cont || (reg_wr && reg_addr == `REG_CONTROL
                                            && reg_wdata[`CTL_CONTINUE])) begin
                    next_s.stop_req = 1'b0;
                    next_s.phase    = s.resume;
                end else if (press.examine) begin
                    next_s.ma    = s.sync2.test_address;
                    next_s.phase = PH_EXAM;
                end else if (press.deposit) begin
                    next_s.ma    = s.sync2.test_address;
                    next_s.mbuf  = s.sync2.test_word;
                    next_s.wr    = 1'b1;
                    next_s.phase = PH_DEP;
                end else if (press.read_in) begin
                    next_s.readin = 1'b1;
                end
            end
            PH_FETCH: begin
                if (s.cnt == 16'h1) begin
                    next_s.mbuf = mem_rdata;
                    next_s.ir = mem_rdata;
                    if (!s.sync2.test) begin
                        next_s.pc = s.pc + 12'h1;
                    end
                end
                if (last) begin
                    if (op == `OP_JMP || op == `OP_JSP) begin
                        if (ind) begin
                            nxt = PH_DEFER;
                        end else begin
                            nxt = PH_FETCH;
                            if (op == `OP_JSP) begin
                                next_s.ac = {6'h00, s.pc};
                            end
                            next_s.pc = s.ir[11:0];
                        end
                        next_s.ma = s.ir[11:0];
                    end else if (is_memref(op)) begin
                        nxt       = ind ? PH_DEFER : PH_EXEC;
                        next_s.ma = s.ir[11:0];
                    end else if (op == `OP_IOT) begin
                        next_s.io_go = 1'b1;
                        nxt = ind ? PH_IOWAIT : PH_FETCH;
                    end else begin
                        // Augmented groups are carried out elsewhere
                        nxt = PH_FETCH;
                    end
                end
            end
            PH_DEFER: begin
                if (s.cnt == 16'h1) begin
                    next_s.mbuf = mem_rdata;
                end
                if (last) begin
                    next_s.ma = s.mbuf[11:0];
                    if (s.mbuf[12]) begin
                        nxt = PH_DEFER;
                    end else if (op == `OP_JMP || op == `OP_JSP) begin
                        if (op == `OP_JSP) begin
                            next_s.ac = {6'h00, s.pc};
                        end
                        next_s.pc = s.mbuf[11:0];
                        nxt = PH_FETCH;
                    end else begin
                        nxt = PH_EXEC;
                    end
                end
            end
            PH_EXEC: begin
                if (s.cnt == 16'h1) begin
                    next_s.mbuf = y;
                    unique case (op)
                        `OP_ADD: begin
                            sum = oc_add(s.ac, y);
                            next_s.ac = sum;
                            if (oc_ovf(s.ac, y, sum)) next_s.ovf = 1'b1;
                        end
                        `OP_SUB: begin
                            sum = oc_add(s.ac, ~y);
                            next_s.ac = sum;
                            if (oc_ovf(s.ac, ~y, sum)) next_s.ovf = 1'b1;
                        end
                        `OP_MUS: begin
                            sum  = s.io[0] ? oc_add(s.ac, y) : s.ac;
                            pair = {1'b0, sum, s.io[17:1]};
                            next_s.ac = pair[35:18];
                            next_s.io = pair[17:0];
                        end
                        `OP_DIS: begin
                            pair = {s.ac[16:0], s.io, ~s.ac[17]};
                            sum  = pair[0] ? oc_add(pair[35:18], ~y)
                                           : oc_add(oc_add(pair[35:18], y), 18'h1);
                            next_s.ac = sum;
                            next_s.io = pair[17:0];
                        end
                        `OP_IDX, `OP_ISP: begin
                            sum = oc_add(y, 18'h1);
                            next_s.ac = sum;
                            next_s.mbuf = sum;
                            next_s.wr = 1'b1;
                            if (op == `OP_ISP && !sum[17]) next_s.pc = s.pc + 12'h1;
                        end
                        `OP_AND: next_s.ac = s.ac & y;
                        `OP_XOR: next_s.ac = s.ac ^ y;
                        `OP_IOR: next_s.ac = s.ac | y;
                        `OP_LAC: next_s.ac = y;
                        `OP_LIO: next_s.io = y;
                        `OP_DAC: begin
                            next_s.mbuf = s.ac;
                            next_s.wr = 1'b1;
                        end
                        `OP_DIO: begin
                            next_s.mbuf = s.io;
                            next_s.wr = 1'b1;
                        end
                        `OP_DAP: begin
                            next_s.mbuf = {y[17:12], s.ac[11:0]};
                            next_s.wr = 1'b1;
                        end
                        `OP_DIP: begin
                            next_s.mbuf = {s.ac[17:12], y[11:0]};
                            next_s.wr = 1'b1;
                        end
                        `OP_SAD: if (y != s.ac) next_s.pc = s.pc + 12'h1;
                        `OP_SAS: if (y == s.ac) next_s.pc = s.pc + 12'h1;
                        default: ;
                    endcase
                end
                if (last) begin
                    nxt = PH_FETCH;
                end
            end
            PH_IOWAIT: begin
                // No memory traffic while the device completes
                if (s.sync2.stop == 1'b0 && io_done) begin
                    nxt = PH_FETCH;
                end
            end
            PH_EXAM: begin
                if (s.cnt == 16'h1) begin
                    next_s.ac = mem_rdata;
                    next_s.mbuf = mem_rdata;
                end
                if (last) begin
                    next_s.phase = PH_HALT;
                end
            end
            PH_DEP: begin
                if (last) begin
                    next_s.wr    = 1'b0;
                    next_s.phase = PH_HALT;
                end
            end
            default: next_s.phase = PH_HALT;
        endcase

        // End of an instruction cycle: continue or park for continue
        if ((last && s.phase inside {PH_FETCH, PH_DEFER, PH_EXEC})
            || (s.phase == PH_IOWAIT && nxt == PH_FETCH)) begin
            next_s.wr = 1'b0;
            if (nxt == PH_FETCH) begin
                next_s.ma = s.sync2.test ? s.sync2.test_address : next_s.pc;
            end
            halting = s.stop_req || s.sync2.single_cycle;
            next_s.phase  = halting ? PH_HALT : nxt;
            next_s.resume = nxt;
        end

        // Stop requests win over the clear made by continue
        if (press.stop || (reg_wr && reg_addr == `REG_CONTROL && reg_wdata[`CTL_STOP])) begin
            next_s.stop_req = 1'b1;
        end

        next_s.rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `REG_STATUS: begin
                    next_s.rdata[`ST_RUNNING]  = (s.phase != PH_HALT);
                    next_s.rdata[`ST_OVERFLOW] = s.ovf;
                    next_s.rdata[`ST_STOP_REQ] = s.stop_req;
                    next_s.rdata[`ST_SENSE_LSB +: 6] = s.sync2.sense;
                end
                `REG_PC: next_s.rdata = {20'h0, s.pc};
                `REG_AC: next_s.rdata = {14'h0, s.ac};
                `REG_IO: next_s.rdata = {14'h0, s.io};
                `REG_MBUF: next_s.rdata = {14'h0, s.mbuf};
                default: next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s          <= '0;
            s.phase    <= PH_HALT;
            s.resume   <= PH_FETCH;
            s.ac       <= `RST_WORD;
            s.io       <= `RST_WORD;
            s.pc       <= `RST_ADDR;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mem.re    = mem_phase && (s.phase != PH_DEP) && (s.cnt == 16'h0);
    assign mem.we    = s.wr && last && (s.phase inside {PH_EXEC, PH_DEP});
    assign mem.addr  = s.ma;
    assign mem.wdata = s.mbuf;

    assign lights.running  = (s.phase != PH_HALT);
    assign lights.overflow = s.ovf;
    assign lights.pc       = s.pc;
    assign lights.ma       = s.ma;
    assign lights.ac       = s.ac;
    assign lights.io       = s.io;
    assign lights.memory_buffer_register = s.mbuf;
    assign lights.ir       = s.ir;

    assign reg_rdata      = s.rdata;
    assign io_start       = s.io_go;
    assign reader_read_in = s.readin;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence cycle_end_s;
        last && (s.phase inside {PH_FETCH, PH_DEFER, PH_EXEC});
    endsequence

    sequence exam_read_s;
        (s.phase == PH_EXAM) && (s.cnt == 16'h1);
    endsequence

    write_at_end_a: assert property (mem.we |-> last && s.phase != PH_FETCH)
        else $error("memory write outside cycle end");
    indirect_extra_a: assert property (cycle_end_s ##0 (s.phase == PH_DEFER && s.mbuf[12]
        && !s.stop_req && !s.sync2.single_cycle) |=> s.phase == PH_DEFER && s.cnt == 16'h0)
        else $error("indirect level skipped a cycle");
    start_entry_a: assert property ((s.phase == PH_HALT && press.start) |=>
        (s.phase == PH_FETCH && s.ma == $past(s.sync2.test_address) && !s.ovf))
        else $error("start did not fetch from switches");
    stop_halt_a: assert property (cycle_end_s ##0 s.stop_req |=> s.phase == PH_HALT)
        else $error("stop not honoured at cycle end");
    exam_load_a: assert property (exam_read_s |=> (s.ac == $past(mem_rdata)) && s.ac == s.mbuf)
        else $error("examine did not load accumulator and buffer");
    single_step_a: assert property (cycle_end_s ##0 s.sync2.single_cycle |=>
        s.phase == PH_HALT ##1 s.phase == PH_HALT)
        else $error("single cycle did not halt");
    ovf_sticky_a: assert property ((s.ovf && !(s.phase == PH_HALT && press.start)) |=> s.ovf)
        else $error("overflow cleared");
    fetch_step_a: assert property ((s.phase == PH_FETCH && s.cnt == 16'h1 && !s.sync2.test)
        |=> s.pc == $past(s.pc) + 12'h1)
        else $error("counter not advanced on fetch");
    deposit_word_a: assert property ((s.phase == PH_DEP && mem.we)
        |-> mem.wdata == s.sync2.test_word && mem.addr == s.sync2.test_address)
        else $error("deposit wrote wrong word");

endmodule

`default_nettype wire

// ==== bench/core_mem_model.sv ====
/*
 * Core memory model for the executor bench, 4096 words of 18 bits.
 * Assumes requests on sys_clk; read data valid one clock after re.
 */
`timescale 1ns/10ps
`default_nettype none
module core_mem_model (
    input  wire logic                 sys_clk,
    input  wire memref_pkg::mem_req_t mem,
    output logic [17:0]               mem_rdata
);
    import memref_pkg::*;
    logic [17:0] arr [0:4095];
    always @(posedge sys_clk) begin
        if (mem.we) begin
            arr[mem.addr] <= mem.wdata;
        end
        // Stale data toggles, so a late sample cannot pass by luck
        mem_rdata <= mem.re ? arr[mem.addr] : ~mem_rdata;
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Self-checking bench of the executor: console, register port, opcodes.
 * Assumes core_mem_model as memory; program loaded through its array.
 */
`timescale 1ns/10ps
`default_nettype none
`include "memref_regs.svh"
module tb;
    import memref_pkg::*;
    localparam int MC = 8;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    console_t    con = '0;
    logic [17:0] mem_rdata, a, b, io, e_ac, e_io, e_m;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, q, lfsr = 32'hEE02;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, io_start, reader_read_in, e_ovf, skip, ind;
    logic        io_done = 1'b0;
    logic [5:0]  op;
    logic [11:0] tgt;
    mem_req_t    mem;
    lights_t     lights;
    int          n_errors = 0, num_checks = 0, n_readin = 0, n_io = 0;
    logic [5:0]  ops [19] = '{`OP_ADD, `OP_SUB, `OP_AND, `OP_IOR, `OP_XOR, `OP_LAC, `OP_LIO,
        `OP_DAC, `OP_DAP, `OP_DIP, `OP_DIO, `OP_IDX, `OP_ISP, `OP_SAD, `OP_SAS, `OP_MUS,
        `OP_DIS, `OP_JMP, `OP_JSP};
    always #5 sys_clk = ~sys_clk;
    memref_exec #(.MC_CYCLES(MC)) i_dut (.sys_clk(sys_clk), .srst(srst), .console(con),
        .mem_rdata(mem_rdata), .io_done(io_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem(mem), .lights(lights),
        .io_start(io_start), .reader_read_in(reader_read_in));
    core_mem_model i_mem (.sys_clk(sys_clk), .mem(mem), .mem_rdata(mem_rdata));
    always @(posedge sys_clk) if (reader_read_in === 1'b1) n_readin++;
    always @(posedge sys_clk) if (io_start === 1'b1) n_io++;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Ones' complement sum with end-around carry
    function automatic logic [17:0] oc_add(input logic [17:0] x, y);
        logic [18:0] s;
        s = x + y;
        return s[17:0] + 18'(s[18]);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Buttons held long enough to pass the input synchroniser
    task automatic press(input int k);
        con[43-k] <= 1'b1;
        tick(5);
        con[43-k] <= 1'b0;
        tick(5);
    endtask
    task automatic reg_rw(input logic [3:0] ad, input logic wr, input logic [31:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        tick(1);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
        tick(1);
    endtask
    task automatic halt_wait();
        for (int i = 0; i < 300 && lights.running !== 1'b0; i++) tick(1);
        if (lights.running !== 1'b0) begin
            n_errors++;
            end_of_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(12);
        srst <= 1'b0;
        tick(3);
        con.test_address <= 12'h155;
        con.test_word <= 18'h2A5A5;
        press(4);
        halt_wait();
        check("deposit", i_mem.arr[12'h155], 18'h2A5A5);
        con.test_word <= 18'h0;
        press(3);
        halt_wait();
        check("exam ac", lights.ac, 18'h2A5A5);
        check("exam mb", lights.memory_buffer_register, 18'h2A5A5);
        press(5);
        check("read-in", n_readin, 1);
        con.sense <= 6'(rnd());
        reg_rw(4'h6, 1'b0, 32'h0);
        check("unmapped", q, 0);
        reg_rw(`REG_STATUS, 1'b0, 32'h0);
        check("sense", q[`ST_SENSE_LSB +: 6], con.sense);
        for (int i = 0; i < 38; i++) begin
            op = ops[i % 19];
            a = 18'(rnd());
            b = (i >= 19) ? a : 18'(rnd());
            io = 18'(rnd());
            ind = rnd() & 1;
            tgt = (op == `OP_JMP || op == `OP_JSP) ? 12'o6 : 12'o101;
            i_mem.arr[0] = {`OP_LIO, 12'o102};
            i_mem.arr[1] = {`OP_LAC, 12'o100};
            i_mem.arr[2] = {op | {5'h0, ind}, ind ? 12'o103 : tgt};
            i_mem.arr[3] = {`OP_JMP, 12'o6};
            i_mem.arr[4] = {`OP_JMP, 12'o10};
            i_mem.arr[6] = {`OP_JMP, 12'o6};
            i_mem.arr[8] = {`OP_JMP, 12'o10};
            i_mem.arr[12'o100] = a;
            i_mem.arr[12'o101] = b;
            i_mem.arr[12'o102] = io;
            i_mem.arr[12'o103] = {6'o01, 12'o104};
            i_mem.arr[12'o104] = {6'h0, tgt};
            {e_ac, e_io, e_m, e_ovf, skip} = {a, io, b, 2'b00};
            case (op)
                `OP_ADD: e_ac = oc_add(a, b);
                `OP_SUB: e_ac = oc_add(a, ~b);
                `OP_AND: e_ac = a & b;
                `OP_IOR: e_ac = a | b;
                `OP_XOR: e_ac = a ^ b;
                `OP_LAC: e_ac = b;
                `OP_LIO: e_io = b;
                `OP_DAC: e_m = a;
                `OP_DIO: e_m = io;
                `OP_DAP: e_m = {b[17:12], a[11:0]};
                `OP_DIP: e_m = {a[17:12], b[11:0]};
                `OP_IDX, `OP_ISP: begin
                    e_ac = oc_add(b, 18'h1);
                    e_m = e_ac;
                    skip = op == `OP_ISP && !e_ac[17];
                end
                `OP_SAD: skip = a != b;
                `OP_SAS: skip = a == b;
                `OP_MUS: begin
                    if (io[0]) e_ac = oc_add(a, b);
                    {e_ac, e_io} = {1'b0, e_ac, io[17:1]};
                end
                `OP_DIS: begin
                    {e_ac, e_io} = {a[16:0], io[17], io[16:0], ~a[17]};
                    e_ac = e_io[0] ? oc_add(e_ac, ~b) : oc_add(e_ac, oc_add(b, 18'h1));
                end
                `OP_JSP: e_ac = 18'h3;
                default: ;
            endcase
            if (op == `OP_ADD || op == `OP_SUB)
                e_ovf = (a[17] ^ b[17]) == (op == `OP_SUB) && e_ac[17] != a[17];
            con.test_address <= 12'h0;
            press(0);
            tick(12 * MC);
            if (i[0])
                press(1);
            else
                reg_rw(4'h5, 1'b1, 32'h1);
            halt_wait();
            check("ac", lights.ac, e_ac);
            check("io", lights.io, e_io);
            check("word", i_mem.arr[12'o101], e_m);
            check("pc", lights.pc[11:1], skip ? 4 : 3);
            check("ovf", lights.overflow, e_ovf);
        end
        // Single cycle with test switch: every continue is one memory cycle
        i_mem.arr[12'o200] = {`OP_IDX, 12'o201};
        i_mem.arr[12'o201] = 18'h0;
        con.single_cycle <= 1'b1;
        con.test <= 1'b1;
        con.test_address <= 12'o200;
        press(0);
        for (int k = 0; k < 4; k++) begin
            halt_wait();
            check("step pc", lights.pc, 12'o200);
            press(2);
        end
        halt_wait();
        check("steps", i_mem.arr[12'o201], 18'h2);
        // In-out transfer with wait: parked until the device reports done
        con.single_cycle <= 1'b0;
        con.test <= 1'b0;
        con.test_address <= 12'o300;
        i_mem.arr[12'o300] = {`OP_IOT | 6'h01, 12'h0};
        i_mem.arr[12'o301] = {`OP_JMP, 12'o302};
        i_mem.arr[12'o302] = {`OP_JMP, 12'o302};
        press(0);
        tick(4 * MC);
        check("io wait", lights.pc, 12'o301);
        check("io run", lights.running, 1'b1);
        io_done <= 1'b1;
        tick(4 * MC);
        press(1);
        halt_wait();
        check("io done", lights.pc, 12'o302);
        check("io start", n_io, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
